// *** core/adcseq_pkg.sv ***
package adcseq_pkg;
   // offsets are register indices; byte address is four times the index
   localparam int unsigned ADDR_W = 18;
   localparam logic [15:0] IDX_CTRL = 16'hfe58;
   localparam logic [15:0] IDX_MODE = 16'hfe59;
   localparam logic [15:0] IDX_LOW = 16'hfe5a;
   localparam logic [15:0] IDX_HIGH = 16'hfe5b;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_LOW = {IDX_LOW, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_HIGH = {IDX_HIGH, 2'h0};

   // field positions
   localparam int unsigned CTRL_CHSEL_LSB = 4;
   localparam int unsigned CTRL_RUN_BIT = 2;
   localparam int unsigned CTRL_DONE_BIT = 1;
   localparam int unsigned CTRL_IE_BIT = 0;
   localparam int unsigned MODE_RES_BIT = 6;
   localparam int unsigned LOW_DATA_LSB = 4;
   localparam int unsigned LOW_TMSB_BIT = 0;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] LOW_RST = 8'h00;
   localparam logic [7:0] HIGH_RST = 8'h00;

   // conversion timing, in thirds of one cycle-clock period
   localparam int unsigned BASE_THIRDS_12 = 52;
   localparam int unsigned BASE_THIRDS_8 = 32;
   localparam int unsigned FIXED_THIRDS = 2;
   localparam int unsigned THIRDS_PER_TCYC = 3;
   localparam int unsigned CNT_W = 16;

   typedef enum logic [1:0] {
      ADCSEQ_SEL_CTRL = 2'b00,
      ADCSEQ_SEL_MODE = 2'b01,
      ADCSEQ_SEL_LOW = 2'b10,
      ADCSEQ_SEL_HIGH = 2'b11
   } adcseq_sel_t;
endpackage

// *** core/adcseq_tmr_if.sv ***
`timescale 1ns/1ps
interface adcseq_tmr_if;
   logic start;
   logic abort;
   logic eight;
   logic dbl;
   logic [2:0] div;
   logic busy;
   logic done;
   modport ctl (output start, output abort, output eight, output dbl, output div,
                input busy, input done);
   modport tmr (input start, input abort, input eight, input dbl, input div,
                output busy, output done);
endinterface

// *** core/adcseq_timer.sv ***
`timescale 1ns/1ps
module adcseq_timer #(
   parameter int unsigned BASE_12 = adcseq_pkg::BASE_THIRDS_12,
   parameter int unsigned BASE_8 = adcseq_pkg::BASE_THIRDS_8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   adcseq_tmr_if.tmr t
);
   logic [adcseq_pkg::CNT_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;

   // thirds rounded up to whole cycles, never under one
   function automatic logic [adcseq_pkg::CNT_W-1:0] conv_cycles(
      input logic [2:0] n, input logic eight, input logic dbl);
      int unsigned thirds;
      int unsigned cyc;
      thirds = ((eight ? BASE_8 : BASE_12) << n) + adcseq_pkg::FIXED_THIRDS; // RULE20 RULE21
      if (dbl) begin // RULE11
         thirds = thirds * 2;
      end
      cyc = (thirds + adcseq_pkg::THIRDS_PER_TCYC - 1) / adcseq_pkg::THIRDS_PER_TCYC;
      if (cyc == 0) begin
         cyc = 1;
      end
      return cyc[adcseq_pkg::CNT_W-1:0];
   endfunction

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (t.abort) begin
            busy_q <= 1'b0;
         end else if (t.start) begin
            cnt_q <= conv_cycles(t.div, t.eight, t.dbl); // RULE24
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == 1) begin
               busy_q <= 1'b0;
               done_q <= 1'b1; // RULE24
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end

   assign t.busy = busy_q;
   assign t.done = done_q;
endmodule

// *** core/adcseq_first_track.sv ***
`timescale 1ns/1ps
module adcseq_first_track (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic mode_wr,
   input wire logic cur_eight,
   input wire logic new_eight,
   input wire logic done12,
   output logic pend_q
);
   // an aborted conversion does not consume the doubled slot
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pend_q <= 1'b1; // RULE11
      end else if (mode_wr && cur_eight && !new_eight) begin
         pend_q <= 1'b1; // RULE11
      end else if (done12) begin
         pend_q <= 1'b0; // RULE12
      end
   end
endmodule

// *** core/adcseq_top.sv ***
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// RULE1: software writes zero to low register bits 2 and 1; they have no function.
// RULE2: divider code is low register bit 0 above mode register bits 1..0.
// RULE3: 12-bit mode puts the upper eight result bits into the high register.
// RULE4: 8-bit mode puts the whole eight-bit result into the high register.
// RULE5: software reads results only after the conversion has completed.
// RULE6: high register is read/write at its fixed index, reset to zero.
// RULE7: mode register bit 6 at zero selects 12-bit resolution.
// RULE8: divider code 101 selects division ratio 1/32.
// RULE9: channel field 0101 in control bits 7..4 routes input five.
// RULE10: writing one to control bit 2 starts a conversion.
// RULE11: first 12-bit conversion after reset or 8-to-12 switch takes double time.
// RULE12: all other conversions take the normal formula time.
// RULE13: software polls done flag bit 1 for one, then writes it to zero.
// RULE14: writing zero to the run bit mid-conversion aborts it, result invalid.
// RULE15: software clears the run bit before entering any standby mode.
// RULE16: reset during a conversion clears run bit and stops the converter.
// RULE17: on completion done flag sets and run bit clears in one cycle.
// RULE18: completion with interrupt enable set raises the interrupt request.
// RULE19: software averages several conversions, dropping highest and lowest.
// RULE20: normal time is (52 or 32 over ratio plus 2) thirds of a cycle.
// RULE21: divider code n gives ratio 1 over 2 to the n.
// RULE22: 12-bit mode writes the lower four result bits to low register top nibble.
// RULE23: 8-bit mode leaves the low register unchanged on a result.
// RULE24: a cycle counter loaded from settings times it; result latched at terminal.
module adcseq_top #(
   parameter int unsigned BASE_12 = adcseq_pkg::BASE_THIRDS_12,
   parameter int unsigned BASE_8 = adcseq_pkg::BASE_THIRDS_8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcseq_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] ana_result,
   output logic [3:0] ana_channel,
   output logic ana_enable,
   output logic ana_twelve_bit,
   output logic ana_sample,
   output logic irq_req
);
   adcseq_tmr_if tif ();

   logic [3:0] chsel_q;
   logic fix3_q;
   logic run_q;
   logic done_q;
   logic ie_q;
   logic [7:0] mode_q;
   logic [7:0] low_q;
   logic [7:0] high_q;
   logic conv_eight_q;
   logic twelve_q;
   logic sample_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic first_pend;

   logic hit;
   logic [2:0] dec;
   adcseq_pkg::adcseq_sel_t sel;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_low;
   logic wr_high;
   logic start;
   logic abort;
   logic [7:0] rd_byte;
   logic [2:0] div_code;
   logic cur_eight;

   // address decode, shared by the read mux and the write strobes
   function automatic logic [2:0] decode(input logic [adcseq_pkg::ADDR_W-1:0] a);
      logic [2:0] r;
      r = 3'h0;
      case (a)
         adcseq_pkg::ADDR_CTRL: begin
            r = {1'b1, adcseq_pkg::ADCSEQ_SEL_CTRL};
         end
         adcseq_pkg::ADDR_MODE: begin
            r = {1'b1, adcseq_pkg::ADCSEQ_SEL_MODE};
         end
         adcseq_pkg::ADDR_LOW: begin
            r = {1'b1, adcseq_pkg::ADCSEQ_SEL_LOW};
         end
         adcseq_pkg::ADDR_HIGH: begin
            r = {1'b1, adcseq_pkg::ADCSEQ_SEL_HIGH}; // RULE6
         end
         default: begin
            r = 3'h0;
         end
      endcase
      return r;
   endfunction

   always_comb begin
      dec = decode(paddr);
      hit = dec[2];
      sel = adcseq_pkg::adcseq_sel_t'(dec[1:0]);
   end

   // writes land only at the edge where pready is seen high
   always_comb begin
      wr_fire = psel && penable && pwrite && pready_q && hit;
      wr_ctrl = wr_fire && (sel == adcseq_pkg::ADCSEQ_SEL_CTRL);
      wr_mode = wr_fire && (sel == adcseq_pkg::ADCSEQ_SEL_MODE);
      wr_low = wr_fire && (sel == adcseq_pkg::ADCSEQ_SEL_LOW);
      wr_high = wr_fire && (sel == adcseq_pkg::ADCSEQ_SEL_HIGH);
   end

   // a one written while already running is ignored, not a restart
   always_comb begin
      // timer busy checked too, so run bit and counter cannot disagree
      start = wr_ctrl && pwdata[adcseq_pkg::CTRL_RUN_BIT] && !run_q && !tif.busy; // RULE10
      abort = wr_ctrl && !pwdata[adcseq_pkg::CTRL_RUN_BIT] && run_q; // RULE14
   end

   always_comb begin
      div_code = {low_q[adcseq_pkg::LOW_TMSB_BIT], mode_q[1:0]}; // RULE2 RULE8 RULE21
      cur_eight = mode_q[adcseq_pkg::MODE_RES_BIT]; // RULE7
   end

   always_comb begin
      tif.start = start;
      tif.abort = abort;
      tif.eight = cur_eight;
      tif.dbl = first_pend && !cur_eight; // RULE11 RULE12
      tif.div = div_code;
   end

   adcseq_timer #(
      .BASE_12(BASE_12), // RULE20
      .BASE_8(BASE_8)
   ) u_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .t(tif.tmr)
   );

   adcseq_first_track u_first (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .mode_wr(wr_mode),
      .cur_eight(cur_eight),
      .new_eight(pwdata[adcseq_pkg::MODE_RES_BIT]),
      .done12(tif.done && !conv_eight_q),
      .pend_q(first_pend)
   );

   // unmapped reads return zero beside pslverr
   always_comb begin
      case (sel)
         adcseq_pkg::ADCSEQ_SEL_CTRL: begin
            rd_byte = {chsel_q, fix3_q, run_q, done_q, ie_q};
         end
         adcseq_pkg::ADCSEQ_SEL_MODE: begin
            rd_byte = mode_q;
         end
         adcseq_pkg::ADCSEQ_SEL_LOW: begin
            rd_byte = low_q;
         end
         adcseq_pkg::ADCSEQ_SEL_HIGH: begin
            rd_byte = high_q;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
      if (!hit) begin
         rd_byte = 8'h00;
      end
   end

   // one wait state: pready rises the cycle after the access phase begins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
      end else if (psel && penable && !pready_q) begin
         pready_q <= 1'b1;
      end else begin
         pready_q <= 1'b0;
      end
   end

   // error stands only beside pready, never on its own
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pslverr_q <= 1'b0;
      end else if (psel && penable && !pready_q) begin
         pslverr_q <= !hit;
      end else begin
         pslverr_q <= 1'b0;
      end
   end

   // read data held until the next access overwrites it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && penable && !pready_q) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // control register: channel, fixed bit 3, interrupt enable
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         chsel_q <= adcseq_pkg::CTRL_RST[7:4];
      end else if (wr_ctrl) begin
         chsel_q <= pwdata[adcseq_pkg::CTRL_CHSEL_LSB +: 4]; // RULE9
      end
   end

   // fixed bit is kept as written; it drives nothing
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fix3_q <= adcseq_pkg::CTRL_RST[3];
      end else if (wr_ctrl) begin
         fix3_q <= pwdata[3];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ie_q <= adcseq_pkg::CTRL_RST[0];
      end else if (wr_ctrl) begin
         ie_q <= pwdata[adcseq_pkg::CTRL_IE_BIT];
      end
   end

   // run bit: completion clears it, software starts or aborts
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         run_q <= adcseq_pkg::CTRL_RST[2]; // RULE16
      end else if (tif.done) begin
         run_q <= 1'b0; // RULE17
      end else if (wr_ctrl) begin
         run_q <= pwdata[adcseq_pkg::CTRL_RUN_BIT]; // RULE10 RULE14
      end
   end

   // done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         done_q <= adcseq_pkg::CTRL_RST[1];
      end else if (tif.done) begin
         done_q <= 1'b1; // RULE17
      end else if (wr_ctrl) begin
         done_q <= pwdata[adcseq_pkg::CTRL_DONE_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode_q <= adcseq_pkg::MODE_RST;
      end else if (wr_mode) begin
         mode_q <= pwdata[7:0];
      end
   end

   // resolution frozen at start so a mid-run mode write cannot skew the store
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         conv_eight_q <= 1'b0;
      end else if (start) begin
         conv_eight_q <= cur_eight;
      end
   end

   // low register; bits 3..1 are stored as written and drive nothing
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         low_q <= adcseq_pkg::LOW_RST;
      end else begin
         if (wr_low) begin
            low_q <= pwdata[7:0];
         end
         if (tif.done && !conv_eight_q) begin // RULE23
            low_q[adcseq_pkg::LOW_DATA_LSB +: 4] <= ana_result[3:0]; // RULE22 RULE24
         end
      end
   end
   // in 8-bit mode the low register keeps its contents on a result

   // result store beats a software write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         high_q <= adcseq_pkg::HIGH_RST; // RULE6
      end else if (tif.done) begin
         if (conv_eight_q) begin
            high_q <= ana_result[7:0]; // RULE4
         end else begin
            high_q <= ana_result[11:4]; // RULE3
         end
      end else if (wr_high) begin
         high_q <= pwdata[7:0]; // RULE6
      end
   end

   // analog core follows the mode bit one cycle behind, not frozen at start
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         twelve_q <= 1'b1;
      end else begin
         twelve_q <= !cur_eight; // RULE7
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sample_q <= 1'b0;
      end else begin
         sample_q <= start;
      end
   end

   // request level follows flag and enable, one cycle behind
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= done_q && ie_q; // RULE18
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ana_channel = chsel_q; // RULE9
   assign ana_enable = run_q; // RULE16
   assign ana_twelve_bit = twelve_q;
   assign ana_sample = sample_q;
   assign irq_req = irq_q;
endmodule

// *** dv/adcseq_props.sv ***
`timescale 1ns/1ps
module adcseq_props #(
   parameter int unsigned BASE_12 = 52,
   parameter int unsigned BASE_8 = 32
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcseq_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] ana_result,
   input wire logic [3:0] ana_channel,
   input wire logic ana_enable,
   input wire logic ana_twelve_bit,
   input wire logic ana_sample,
   input wire logic irq_req
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic wr_c;
   logic wr_m;
   assign wr_c = psel && penable && pready && pwrite && paddr == adcseq_pkg::ADDR_CTRL;
   assign wr_m = psel && penable && pready && pwrite && paddr == adcseq_pkg::ADDR_MODE;
   chk_run_start: assert property (wr_c && pwdata[2] && !ana_enable |=> ana_enable && ana_sample)
      else $error("start write did not raise run");
   chk_run_abort: assert property (wr_c && !pwdata[2] |=> !ana_enable)
      else $error("stop write did not drop run");
   chk_chan_route: assert property (wr_c |=> ana_channel == $past(pwdata[7:4]))
      else $error("channel not routed");
   chk_res_select: assert property (wr_m |-> ##2 ana_twelve_bit == !$past(pwdata[6], 2))
      else $error("resolution not applied");
   chk_reset_stop: assert property (disable iff (1'b0) sys_rst |=> !ana_enable && !irq_req)
      else $error("reset left converter running");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stood too long");
   chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error read returned data");
   chk_map_ok: assert property (pready && paddr == adcseq_pkg::ADDR_HIGH |-> !pslverr)
      else $error("high register refused");
   chk_sample_once: assert property (ana_sample |-> ana_enable ##1 !ana_sample)
      else $error("sample pulse wrong");
endmodule
bind adcseq_top adcseq_props #(.BASE_12(BASE_12), .BASE_8(BASE_8)) adcseq_props_i (.ref_clk,
   .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ana_result,
   .ana_channel, .ana_enable, .ana_twelve_bit, .ana_sample, .irq_req);

// *** dv/adcseq_ana_model.sv ***
`timescale 1ns/1ps
module adcseq_ana_model (
   input wire logic ref_clk,
   input wire logic [3:0] ana_channel,
   input wire logic ana_enable,
   input wire logic ana_sample,
   output logic [11:0] ana_result
);
   logic [11:0] val_q = 12'h000;
   // value encodes the routed input so a wrong channel shows in the result
   always @(posedge ref_clk) begin
      if (ana_sample) begin
         val_q <= {ana_channel, 4'h9, ana_channel ^ 4'h6};
      end
   end
   // idle core does not hold its result: inverse shows a stray latch
   assign ana_result = ana_enable ? val_q : ~val_q;
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   localparam int unsigned B12 = 4;
   localparam int unsigned B8 = 2;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [adcseq_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ana_enable, ana_twelve_bit, ana_sample, irq_req, err;
   logic [11:0] ana_result;
   logic [3:0] ana_channel;
   logic [31:0] rd;
   logic [31:0] hv;
   int fail_count = 0;
   int comparisons = 0;
   always #5 ref_clk = ~ref_clk;
   adcseq_top #(.BASE_12(B12), .BASE_8(B8)) adcseq_top_i (.ref_clk, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ana_result, .ana_channel,
      .ana_enable, .ana_twelve_bit, .ana_sample, .irq_req);
   adcseq_ana_model adcseq_ana_model_i (.ref_clk, .ana_channel, .ana_enable, .ana_sample,
      .ana_result);
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [17:0] a, input logic [7:0] e, input string s);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, e}, s);
   endtask
   function automatic int cyc(input int b, input int n, input int d);
      return ((((b << n) + 2) * d) + 2) / 3;
   endfunction
   task automatic setup(input logic eight, input logic [2:0] n, input logic [3:0] lo);
      apb(1'b1, adcseq_pkg::ADDR_LOW, {lo, 3'b000, n[2]});
      apb(1'b1, adcseq_pkg::ADDR_MODE, {1'b0, eight, 4'h0, n[1:0]});
   endtask
   // times the run output from the start edge, then reads done once, checks it and clears it
   task automatic conv(input logic [3:0] ch, input logic ie, input int c);
      int k;
      k = 0;
      apb(1'b1, adcseq_pkg::ADDR_CTRL, {ch, 4'h4} | ie);
      #1;
      check(ana_sample, 1'b1, "sample");
      do begin
         @(posedge ref_clk);
         #1 k++;
      end while (ana_enable === 1'b1 && k < 2000);
      check(k, c + 1, "conversion time");
      rchk(adcseq_pkg::ADDR_CTRL, {ch, 4'h2} | ie, "done and run");
      check(irq_req, ie, "irq raised");
      apb(1'b1, adcseq_pkg::ADDR_CTRL, {ch, 4'h0} | ie);
      repeat (2) @(posedge ref_clk);
      check(irq_req, 1'b0, "irq cleared");
   endtask
   task automatic res_chk(input logic [3:0] ch, input logic eight, input logic [3:0] lo,
                          input logic [2:0] n);
      logic [11:0] r;
      r = {ch, 4'h9, ch ^ 4'h6};
      rchk(adcseq_pkg::ADDR_HIGH, eight ? r[7:0] : r[11:4], "high result");
      rchk(adcseq_pkg::ADDR_LOW, {eight ? lo : r[3:0], 3'b000, n[2]}, "low");
   endtask
   task automatic t_reset();
      rchk(adcseq_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
      rchk(adcseq_pkg::ADDR_MODE, 8'h00, "mode reset");
      rchk(adcseq_pkg::ADDR_LOW, 8'h00, "low reset");
      rchk(adcseq_pkg::ADDR_HIGH, 8'h00, "high reset");
      check(ana_twelve_bit, 1'b1, "twelve default");
      apb(1'b1, adcseq_pkg::ADDR_HIGH, 8'h3c);
      rchk(adcseq_pkg::ADDR_HIGH, 8'h3c, "high rw");
      apb(1'b0, 18'h00010, 8'h00);
      check(err, 1'b1, "unmapped");
   endtask
   task automatic t_twelve();
      setup(1'b0, 3'd5, 4'h0);
      conv(4'h5, 1'b1, cyc(B12, 5, 2));
      res_chk(4'h5, 1'b0, 4'h0, 3'd5);
      conv(4'h5, 1'b0, cyc(B12, 5, 1));
      res_chk(4'h5, 1'b0, 4'h0, 3'd5);
   endtask
   // every divider code in 8-bit mode, low nibble must survive
   task automatic t_eight();
      for (int n = 0; n < 8; n++) begin
         setup(1'b1, n[2:0], 4'ha);
         conv(n[3:0], n[0], cyc(B8, n, 1));
         res_chk(n[3:0], 1'b1, 4'ha, n[2:0]);
      end
      setup(1'b0, 3'd0, 4'h0);
      conv(4'h3, 1'b1, cyc(B12, 0, 2));
      conv(4'h3, 1'b0, cyc(B12, 0, 1));
   endtask
   task automatic t_abort();
      setup(1'b0, 3'd7, 4'h0);
      apb(1'b0, adcseq_pkg::ADDR_HIGH, 8'h00);
      hv = rd;
      apb(1'b1, adcseq_pkg::ADDR_CTRL, 8'h54);
      apb(1'b1, adcseq_pkg::ADDR_CTRL, 8'h50);
      repeat (cyc(B12, 7, 1) + 5) @(posedge ref_clk);
      rchk(adcseq_pkg::ADDR_CTRL, 8'h50, "no done after abort");
      rchk(adcseq_pkg::ADDR_HIGH, hv[7:0], "no store after abort");
   endtask
   task automatic t_rst_mid();
      apb(1'b1, adcseq_pkg::ADDR_CTRL, 8'h54);
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      check(ana_enable, 1'b0, "reset stops");
      rchk(adcseq_pkg::ADDR_CTRL, 8'h00, "run cleared by reset");
      conv(4'h1, 1'b0, cyc(B12, 0, 2));
   endtask
   task automatic end_sim();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_twelve();
      t_eight();
      t_abort();
      t_rst_mid();
      end_sim();
   end
   // well above the summed conversion and bus times
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
endmodule
